// >>> hdl/sfe_front_end.sv
// Serial host-interface front end: framing, sampling, shifting, dual read
`timescale 1ns/10ps
`default_nettype none
`include "sfe_cfg.svh"

// Functional notes
// - Deselected: standby, not deep power-down, upper lane released.
// - Deselected: input lane ignored, no command, address or data taken.
// - Each operation starts only after chip select falls.
// - Select rising during internal operation delays standby until done.
// - Input bits sampled on each rising serial clock edge.
// - Output data changes only on falling clock edges, one bit each outside dual read.
// - Dual read data phase drives input pin as output, two bits/edge.
// - Modes 0 and 3 both work; idle clock level picks the mode.
// - Upper data lane carries the high bit of each dual pair.
module sfe_front_end (
    // Clock and reset
    input  wire logic               core_clk_in,
    input  wire logic               reset_in,
    // Serial pins
    input  wire logic               chip_sel_n_in,
    input  wire logic               sck_in,
    input  wire logic               lower_data_lane_in,
    output logic                    lower_data_lane_out,
    output logic                    lower_data_lane_oe_out,
    output logic                    upper_data_lane_out,
    output logic                    upper_data_lane_oe_out,
    // Core side
    input  wire logic               internal_busy_in,
    input  wire logic [7:0]         tx_byte_in,
    output logic [7:0]              rx_byte_out,
    output logic                    rx_valid_out,
    output logic                    tx_load_out,
    output logic                    standby_out,
    output logic                    mode3_out
);
    import sfe_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchronisers; the first stage feeds only the second
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic       sck_prev_q;
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s1_q       <= 3'h7;
            s2_q       <= 3'h7;
            sck_prev_q <= 1'h1;
        end else begin
            s1_q       <= {chip_sel_n_in, sck_in, lower_data_lane_in};
            s2_q       <= s1_q;
            sck_prev_q <= s2_q[1];
        end
    end
    logic cs_n;
    logic sck;
    logic sdi;
    logic cs_prev_q;
    assign cs_n = s2_q[2];
    assign sck  = s2_q[1];
    assign sdi  = s2_q[0];
    logic rise;
    logic fall;
    logic cs_fall;
    logic cs_rise;
    // Edges count only while selected, so nothing is taken when deselected
    assign rise    = sck & ~sck_prev_q & ~cs_n;
    assign fall    = ~sck & sck_prev_q & ~cs_n;
    assign cs_fall = ~cs_n & cs_prev_q;
    assign cs_rise = cs_n & ~cs_prev_q;

    ////////////////////////////////////////////////////////////////////////
    // Frame state
    sfe_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] rx_q, rx_d;
    logic [7:0] tx_q, tx_d;
    logic [3:0] byte_q, byte_d;
    logic       dualcmd_q, dualcmd_d;
    logic       l0_d, l0oe_d, l1_d, l1oe_d, rv_d, tl_d, sb_d, m3_d;
    logic [7:0] rxb_d;

    always_comb begin
        st_d      = st_q;
        bit_d     = bit_q;
        rx_d      = rx_q;
        tx_d      = tx_q;
        byte_d    = byte_q;
        dualcmd_d = dualcmd_q;
        l0_d      = lower_data_lane_out;
        l0oe_d    = lower_data_lane_oe_out;
        l1_d      = upper_data_lane_out;
        l1oe_d    = upper_data_lane_oe_out;
        rv_d      = 1'h0;
        tl_d      = 1'h0;
        sb_d      = standby_out;
        m3_d      = mode3_out;
        rxb_d     = rx_byte_out;
        unique case (st_q)
            SFE_IDLE, SFE_BUSYWT: begin
                l0oe_d = 1'h0;
                l1oe_d = 1'h0;
                if (st_q == SFE_BUSYWT && !internal_busy_in) begin
                    st_d = SFE_IDLE;
                    sb_d = 1'h1;
                end
                if (cs_fall) begin
                    st_d = SFE_SHIFT;
                    sb_d = 1'h0;
                    m3_d = sck;
                    bit_d = `SFE_CNT_ZERO;
                    byte_d = `SFE_CNT_ZERO;
                    dualcmd_d = 1'h0;
                end
            end
            SFE_SHIFT, SFE_DUAL: begin
                if (rise && st_q == SFE_SHIFT) begin
                    rx_d = {rx_q[6:0], sdi};
                    bit_d = bit_q + 4'h1;
                    if (bit_q == `SFE_CNT_LAST) begin
                        rv_d = 1'h1;
                        rxb_d = {rx_q[6:0], sdi};
                        bit_d = `SFE_CNT_ZERO;
                        tx_d = tx_byte_in;
                        tl_d = 1'h1;
                        byte_d = byte_q + 4'h1;
                        if (byte_q == `SFE_CNT_ZERO &&
                            {rx_q[6:0], sdi} == `SFE_CMD_DUALRD)
                            dualcmd_d = 1'h1;
                        if (dualcmd_q && byte_q == `SFE_DUMMY_BYTES)
                            st_d = SFE_DUAL;
                    end
                end
                if (fall && st_q == SFE_SHIFT) begin
                    l1oe_d = 1'h1;
                    l1_d = tx_q[7];
                    tx_d = {tx_q[6:0], 1'h0};
                end
                if (fall && st_q == SFE_DUAL) begin
                    l0oe_d = 1'h1;
                    l1oe_d = 1'h1;
                    l1_d = tx_q[7];
                    l0_d = tx_q[6];
                    tx_d = {tx_q[5:0], 2'h0};
                    bit_d = bit_q + 4'h1;
                    if (bit_q == `SFE_DUAL_LAST) begin
                        bit_d = `SFE_CNT_ZERO;
                        tx_d = tx_byte_in;
                        tl_d = 1'h1;
                    end
                end
                if (cs_n) begin
                    l0oe_d = 1'h0;
                    l1oe_d = 1'h0;
                    st_d = internal_busy_in ? SFE_BUSYWT : SFE_IDLE;
                    sb_d = ~internal_busy_in;
                end
            end
            default: st_d = SFE_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st_q                   <= SFE_IDLE;
            bit_q                  <= `SFE_CNT_ZERO;
            rx_q                   <= 8'h00;
            tx_q                   <= 8'h00;
            byte_q                 <= `SFE_CNT_ZERO;
            dualcmd_q              <= 1'h0;
            cs_prev_q              <= 1'h1;
            lower_data_lane_out    <= 1'h0;
            lower_data_lane_oe_out <= 1'h0;
            upper_data_lane_out    <= 1'h0;
            upper_data_lane_oe_out <= 1'h0;
            rx_valid_out           <= 1'h0;
            tx_load_out            <= 1'h0;
            standby_out            <= 1'h1;
            mode3_out              <= 1'h0;
            rx_byte_out            <= 8'h00;
        end else begin
            st_q                   <= st_d;
            bit_q                  <= bit_d;
            rx_q                   <= rx_d;
            tx_q                   <= tx_d;
            byte_q                 <= byte_d;
            dualcmd_q              <= dualcmd_d;
            cs_prev_q              <= cs_n;
            lower_data_lane_out    <= l0_d;
            lower_data_lane_oe_out <= l0oe_d;
            upper_data_lane_out    <= l1_d;
            upper_data_lane_oe_out <= l1oe_d;
            rx_valid_out           <= rv_d;
            tx_load_out            <= tl_d;
            standby_out            <= sb_d;
            mode3_out              <= m3_d;
            rx_byte_out            <= rxb_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    a_desel_release: assert property (@(posedge core_clk_in)
        disable iff (reset_in) $past(cs_n, 2) && $past(cs_n)
        |-> !upper_data_lane_oe_out && !lower_data_lane_oe_out)
        else $error("lanes driven while deselected");
    a_desel_norx: assert property (@(posedge core_clk_in)
        disable iff (reset_in) $past(cs_n) |-> !rx_valid_out)
        else $error("byte accepted while deselected");
    a_start_edge: assert property (@(posedge core_clk_in)
        disable iff (reset_in) $rose(st_q == SFE_SHIFT) |-> $past(cs_fall))
        else $error("frame started without select edge");
    a_busy_wait: assert property (@(posedge core_clk_in)
        disable iff (reset_in) st_q == SFE_BUSYWT && internal_busy_in
        |=> !standby_out)
        else $error("standby during internal operation");
    a_rx_on_rise: assert property (@(posedge core_clk_in)
        disable iff (reset_in) rx_valid_out |-> $past(rise))
        else $error("byte completed without rising edge");
    a_out_on_fall: assert property (@(posedge core_clk_in)
        disable iff (reset_in) $changed(upper_data_lane_out)
        |-> $past(fall))
        else $error("output changed off falling edge");
    a_dual_drive: assert property (@(posedge core_clk_in)
        disable iff (reset_in) $rose(lower_data_lane_oe_out)
        |-> $past(st_q == SFE_DUAL) && $past(fall))
        else $error("lower lane driven outside dual phase");
    a_mode_latch: assert property (@(posedge core_clk_in)
        disable iff (reset_in) cs_fall && st_q == SFE_IDLE
        |=> mode3_out == $past(sck))
        else $error("mode not taken from idle clock");
    a_cs_end: assert property (@(posedge core_clk_in)
        disable iff (reset_in) cs_rise |=> st_q != SFE_SHIFT
        && st_q != SFE_DUAL && !upper_data_lane_oe_out
        && !lower_data_lane_oe_out)
        else $error("select rise did not end command");
    // Standby is deferred in two steps: hold off, then enter once idle
    sequence s_end_busy;
        (st_q == SFE_SHIFT || st_q == SFE_DUAL) && cs_n && internal_busy_in;
    endsequence
    sequence s_busy_done;
        st_q == SFE_BUSYWT && !internal_busy_in && !cs_fall;
    endsequence
    a_end_busy: assert property (@(posedge core_clk_in)
        disable iff (reset_in) s_end_busy
        |=> st_q == SFE_BUSYWT && !standby_out)
        else $error("standby entered before internal operation ended");
    a_busy_done: assert property (@(posedge core_clk_in)
        disable iff (reset_in) s_busy_done
        |=> st_q == SFE_IDLE && standby_out)
        else $error("standby not entered after internal operation");
    a_dual_pair: assert property (@(posedge core_clk_in)
        disable iff (reset_in) st_q == SFE_DUAL && fall
        |=> upper_data_lane_out == $past(tx_q[7])
        && lower_data_lane_out == $past(tx_q[6]))
        else $error("dual pair placed on wrong lanes");
endmodule // sfe_front_end
`default_nettype wire

// >>> hdl/sfe_cfg.svh
// Constants for the serial flash host-interface front end
`ifndef SFE_CFG_SVH
`define SFE_CFG_SVH
`define SFE_BYTE_BITS   4'h8
`define SFE_CNT_ZERO    4'h0
`define SFE_CNT_LAST    4'h7
`define SFE_DUAL_LAST   4'h3
`define SFE_CMD_DUALRD  8'h3b
`define SFE_DUMMY_BYTES 4'h4
`endif

// >>> hdl/sfe_pkg.sv
// Types for the serial flash host-interface front end
package sfe_pkg;
    typedef enum logic [1:0] {
        SFE_IDLE   = 2'h0,
        SFE_SHIFT  = 2'h1,
        SFE_DUAL   = 2'h3,
        SFE_BUSYWT = 2'h2
    } sfe_state_t;
endpackage

// >>> test/sfe_host.sv
// Host model: drives select, serial clock and the lower lane
`timescale 1ns/10ps
`default_nettype none
module sfe_host (
    // Clock
    input  wire logic core_clk_in,
    // Lanes as seen on the wire
    input  wire logic up_pin_in,
    input  wire logic lo_pin_in,
    // Host pins
    output logic      cs_n_out,
    output logic      sck_out,
    output logic      si_out,
    output logic      si_oe_out
);
    logic idle_q = 1'b0;
    initial begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        si_out = 1'b0;
        si_oe_out = 1'b1;
    end
    // Half link period, launched just after a core edge
    task automatic half();
        repeat (16) @(posedge core_clk_in);
        #1;
    endtask
    task automatic start(input logic mode);
        idle_q = mode;
        si_oe_out = 1'b1;
        sck_out = mode;
        half();
        cs_n_out = 1'b0;
        half();
    endtask
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sck_out = 1'b0;
            si_out = b[i];
            half();
            sck_out = 1'b1;
            half();
        end
    endtask
    task automatic read_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sck_out = 1'b0;
            half();
            b[i] = up_pin_in;
            sck_out = 1'b1;
            half();
        end
    endtask
    task automatic dual_read(output logic [7:0] b);
        // Released lane floats: show the inverse, not the old value
        si_oe_out = 1'b0;
        si_out = ~si_out;
        for (int k = 3; k >= 0; k--) begin
            sck_out = 1'b0;
            half();
            b[2*k+1] = up_pin_in;
            b[2*k] = lo_pin_in;
            sck_out = 1'b1;
            half();
        end
    endtask
    task automatic stop();
        sck_out = idle_q;
        half();
        cs_n_out = 1'b1;
        half();
    endtask
endmodule // sfe_host
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the serial flash front end
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic       clk, rst, busy, cs_n, sck, si, si_oe, tl;
    logic       lo_out, lo_oe, up_out, up_oe, rx_v, stby, m3;
    logic [7:0] rx_byte, txb;
    wire        lo = lo_oe ? lo_out : si;
    wire        up = up_oe ? up_out : ~up_out;
    int         bad_count = 0, tests_run = 0, rx_cnt = 0;
    int         tl_cnt = 0, clash_cnt = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (rx_v === 1'b1) rx_cnt <= rx_cnt + 1;
    always @(posedge clk) if (tl === 1'b1) tl_cnt <= tl_cnt + 1;
    // Both ends driving the lower lane at once is contention
    always @(posedge clk)
        if (lo_oe === 1'b1 && si_oe === 1'b1) clash_cnt <= clash_cnt + 1;
    sfe_front_end i_sfe_front_end (.core_clk_in(clk), .reset_in(rst),
        .chip_sel_n_in(cs_n), .sck_in(sck), .lower_data_lane_in(lo),
        .lower_data_lane_out(lo_out), .lower_data_lane_oe_out(lo_oe),
        .upper_data_lane_out(up_out), .upper_data_lane_oe_out(up_oe),
        .internal_busy_in(busy), .tx_byte_in(txb), .rx_byte_out(rx_byte),
        .rx_valid_out(rx_v), .tx_load_out(tl), .standby_out(stby),
        .mode3_out(m3));
    sfe_host i_sfe_host (.core_clk_in(clk), .up_pin_in(up), .lo_pin_in(lo),
        .cs_n_out(cs_n), .sck_out(sck), .si_out(si), .si_oe_out(si_oe));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("mismatches=%0d compares=%0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_deselect();
        int n = rx_cnt;
        int m = tl_cnt;
        i_sfe_host.send(8'h3b);
        check(8'(rx_cnt - n), 8'h00);
        check(8'(tl_cnt - m), 8'h00);
        check({6'h0, lo_oe, up_oe}, 8'h00);
        check({7'h0, stby}, 8'h01);
    endtask
    task automatic t_single(input logic mode);
        int n = rx_cnt;
        int m = tl_cnt;
        logic [7:0] got;
        txb = mode ? 8'h96 : 8'h69;
        i_sfe_host.start(mode);
        check({7'h0, m3}, {7'h0, mode});
        i_sfe_host.send(8'h5a);
        check(rx_byte, 8'h5a);
        check(8'(rx_cnt - n), 8'h01);
        i_sfe_host.read_byte(got);
        check(got, mode ? 8'h96 : 8'h69);
        check(8'(tl_cnt - m), 8'h02);
        i_sfe_host.stop();
        check({6'h0, lo_oe, up_oe}, 8'h00);
        check({7'h0, stby}, 8'h01);
    endtask
    task automatic t_dual();
        logic [7:0] got;
        int k;
        int m = tl_cnt;
        txb = 8'hc6;
        busy = 1'b1;
        i_sfe_host.start(1'b0);
        i_sfe_host.send(8'h3b);
        for (k = 0; k < 4; k++) i_sfe_host.send(8'h10 + 8'(k));
        i_sfe_host.dual_read(got);
        check(got, 8'hc6);
        check({7'h0, lo_oe}, 8'h01);
        i_sfe_host.stop();
        check({6'h0, lo_oe, up_oe}, 8'h00);
        check({7'h0, stby}, 8'h00);
        check(8'(tl_cnt - m), 8'h06);
        check(8'(clash_cnt), 8'h00);
        busy = 1'b0;
        for (k = 0; k < 20 && stby !== 1'b1; k++) @(posedge clk);
        check({7'h0, stby}, 8'h01);
        if (stby !== 1'b1) wrap_up();
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        busy = 1'b0;
        txb = 8'h00;
        repeat (20) @(posedge clk);
        #1;
        check({6'h0, lo_oe, up_oe}, 8'h00);
        rst = 1'b0;
        t_deselect();
        t_single(1'b0);
        t_single(1'b1);
        t_dual();
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
